/* common/ddm_pkg.sv */
// Constants, encodings and timing counts of the drive diagnostic monitor.
// Assumes a single 125 MHz clock domain shared by every user of this package.
package ddm_pkg;

  // Parameter addresses seen by the fieldbus parameter port.
  localparam logic [15:0] DDM_ADDR_TEMP_WARN = 16'h100C;
  localparam logic [15:0] DDM_ADDR_TEMP_MAX = 16'h100E;
  localparam logic [15:0] DDM_ADDR_TEMP_ACT = 16'h1C20;
  localparam logic [15:0] DDM_ADDR_OVERLOAD = 16'h1C32;
  localparam logic [15:0] DDM_ADDR_MEAN_LOAD = 16'h1C34;
  localparam logic [15:0] DDM_RDATA_RESET = 16'h0000;

  // Base tick of all indicator and persistence timing.
  localparam int DDM_CLK_PERIOD_NS = 8;
  localparam int DDM_TICK_TIME_NS = 50_000_000;
  localparam int DDM_TICK_CYCLES = DDM_TICK_TIME_NS / DDM_CLK_PERIOD_NS;
  localparam int DDM_TICK_MS = 50;

  // Over-temperature persistence, counted in ticks.
  localparam int DDM_OVER_TEMP_MS = 5000;
  localparam logic [6:0] DDM_OVER_TEMP_TICKS = 7'(DDM_OVER_TEMP_MS / DDM_TICK_MS);
  localparam logic [6:0] DDM_OVER_LIM = DDM_OVER_TEMP_TICKS + 7'h01;

  // Indicator intervals: flash on and off times and the long pause.
  localparam int DDM_FLASH_MS = 200;
  localparam int DDM_PAUSE_MS = 1000;
  localparam logic [5:0] DDM_FLASH_TICKS = 6'(DDM_FLASH_MS / DDM_TICK_MS);
  localparam logic [5:0] DDM_PAUSE_TICKS = 6'(DDM_PAUSE_MS / DDM_TICK_MS);
  localparam logic [5:0] DDM_BLINK_PERIOD = 6'(2 * DDM_FLASH_TICKS);
  localparam logic [5:0] DDM_SINGLE_PERIOD = DDM_FLASH_TICKS + DDM_PAUSE_TICKS;
  localparam logic [5:0] DDM_DOUBLE_PERIOD = 6'(3 * DDM_FLASH_TICKS) + DDM_PAUSE_TICKS;

  typedef enum logic [1:0] {
    DDM_BUS_INIT = 2'b00,
    DDM_BUS_PREOP = 2'b01,
    DDM_BUS_SAFEOP = 2'b10,
    DDM_BUS_OP = 2'b11
  } ddm_bus_state_t;

  typedef enum logic [3:0] {
    DDM_OPS_START = 4'b0001,
    DDM_OPS_NOT_READY = 4'b0010,
    DDM_OPS_SW_ON_DIS = 4'b0011,
    DDM_OPS_READY = 4'b0100,
    DDM_OPS_SWITCHED_ON = 4'b0101,
    DDM_OPS_OP_ENABLED = 4'b0110,
    DDM_OPS_QUICK_STOP = 4'b0111,
    DDM_OPS_FAULT_REACT = 4'b1000,
    DDM_OPS_FAULT = 4'b1001
  } ddm_op_state_t;

  typedef enum logic [2:0] {
    DDM_PAT_OFF = 3'b000,
    DDM_PAT_ON = 3'b001,
    DDM_PAT_FLICKER = 3'b010,
    DDM_PAT_BLINK = 3'b011,
    DDM_PAT_SINGLE = 3'b100,
    DDM_PAT_DOUBLE = 3'b101
  } ddm_pat_t;

endpackage

/* common/ddm_pattern_if.sv */
// Carries the shared tick and the indicator flash patterns between modules.
// Assumes producer and consumer share clk_i.
`timescale 1ns/1ps
interface ddm_pattern_if;
  logic tick;
  logic flicker;
  logic blink;
  logic single_flash;
  logic double_flash;
  modport gen (output tick, output flicker, output blink, output single_flash,
    output double_flash);
  modport use_side (input tick, input flicker, input blink, input single_flash,
    input double_flash);
endinterface

/* hw/ddm_flash_gen.sv */
// Tick and indicator pattern generator of the drive diagnostic monitor.
// Assumes clk_i runs at 125 MHz; TICK_CYCLES may be cut down in simulation.
`timescale 1ns/1ps
module ddm_flash_gen import ddm_pkg::*; #(
  parameter int TICK_CYCLES = DDM_TICK_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  ddm_pattern_if.gen pat
);

  logic [31:0] tick_cnt;
  logic tick;
  logic flick;
  logic [5:0] blink_ph;
  logic [5:0] single_ph;
  logic [5:0] double_ph;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tick_cnt <= 32'h00000000;
      tick <= 1'b0;
    end else if (tick_cnt == 32'(TICK_CYCLES - 1)) begin
      tick_cnt <= 32'h00000000;
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 32'h00000001;
      tick <= 1'b0;
    end
  end

  // Every pattern steps on the same tick so they stay in phase. [R12]
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flick <= 1'b0;
      blink_ph <= 6'h00;
      single_ph <= 6'h00;
      double_ph <= 6'h00;
    end else if (tick) begin
      flick <= !flick;
      blink_ph <= (blink_ph == DDM_BLINK_PERIOD - 6'h01) ? 6'h00 : blink_ph + 6'h01;
      single_ph <= (single_ph == DDM_SINGLE_PERIOD - 6'h01) ? 6'h00 : single_ph + 6'h01;
      double_ph <= (double_ph == DDM_DOUBLE_PERIOD - 6'h01) ? 6'h00 : double_ph + 6'h01;
    end
  end

  assign pat.tick = tick;
  assign pat.flicker = flick;
  assign pat.blink = blink_ph < DDM_FLASH_TICKS; // R12
  assign pat.single_flash = single_ph < DDM_FLASH_TICKS; // R12
  assign pat.double_flash = (double_ph < DDM_FLASH_TICKS) ||
    ((double_ph >= 6'(2 * DDM_FLASH_TICKS)) && (double_ph < 6'(3 * DDM_FLASH_TICKS))); // R12

  blink_restart_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R12
    (tick && blink_ph == DDM_BLINK_PERIOD - 6'h01) |=> pat.blink)
    else $error("blink did not restart at period end");

  single_off_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R12
    (tick && single_ph == DDM_FLASH_TICKS - 6'h01) |=> !pat.single_flash ##1 !pat.single_flash)
    else $error("single flash stayed on past its on time");

endmodule // ddm_flash_gen

/* hw/ddm_diag_monitor.sv */
// Drive diagnostic monitor: temperature and load supervision, read-only
// fieldbus parameters, operating-state LEDs and fieldbus status LEDs.
// Assumes all inputs except the link and activity pins share clk_i.
//
// Contract
// [R1] Class 3 error after over five seconds hot.
// [R2] Class 0 error at warning temperature threshold.
// [R3] Present temperature readable, signed, not writable.
// [R4] Limit current while load integral exceeds limit.
// [R5] Lift limit once integral below limit.
// [R6] Overload and mean load readable, not writable.
// [R7] Green and red LEDs show state, errors.
// [R8] Distinct LED patterns per state group.
// [R9] Link LEDs: off, steady, fast flashing.
// [R10] Run LED follows fieldbus communication state.
// [R11] Error LED: double, single, flashing, off.
// [R12] Flash patterns from fixed clock-derived intervals.
`timescale 1ns/1ps
module ddm_diag_monitor import ddm_pkg::*; #(
  parameter int TICK_CYCLES = DDM_TICK_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [15:0] temp_i,
  input wire logic [15:0] temp_warn_limit_i,
  input wire logic [15:0] temp_max_i,
  input wire logic fault_reset_i,
  input wire logic [15:0] load_integral_i,
  input wire logic [15:0] load_integral_limit_i,
  input wire logic [15:0] overload_pct_i,
  input wire logic [15:0] mean_load_pct_i,
  input wire logic par_rd_i,
  input wire logic par_wr_i,
  input wire logic [15:0] par_addr_i,
  output logic par_ack_o,
  output logic par_err_o,
  output logic [15:0] par_rdata_o,
  output logic err_class0_o,
  output logic err_class3_o,
  output logic current_limit_o,
  input wire logic [3:0] op_state_i,
  input wire logic fw_missing_i,
  input wire logic internal_err_i,
  output logic state_led_green_o,
  output logic state_led_red_o,
  input wire logic link_in_i,
  input wire logic act_in_i,
  input wire logic link_out_i,
  input wire logic act_out_i,
  output logic bus_led_green_o,
  output logic bus_led_red_o,
  input wire logic [1:0] bus_state_i,
  output logic run_led_o,
  input wire logic wdog_timeout_i,
  input wire logic local_err_i,
  input wire logic invalid_cfg_i,
  output logic err_led_o
);

  ddm_pattern_if pat ();

  ddm_flash_gen #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_flash (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .pat(pat)
  );

  logic [3:0] pin_s1;
  logic [3:0] pin_s2;
  logic [1:0] act_recent;
  logic temp_hot;
  logic temp_warn;
  logic [6:0] over_cnt;
  logic addr_hit;
  logic [15:0] next_rdata;
  ddm_pat_t g_pat;
  ddm_pat_t r_pat;
  ddm_pat_t run_pat;
  ddm_pat_t err_pat;

  function automatic logic pat_level(input ddm_pat_t p, input logic [3:0] f);
    logic lvl;
    lvl = 1'b0;
    case (p)
      DDM_PAT_OFF: lvl = 1'b0;
      DDM_PAT_ON: lvl = 1'b1;
      DDM_PAT_FLICKER: lvl = f[0];
      DDM_PAT_BLINK: lvl = f[1];
      DDM_PAT_SINGLE: lvl = f[2];
      DDM_PAT_DOUBLE: lvl = f[3];
      default: lvl = 1'b0;
    endcase
    return lvl;
  endfunction

  logic [3:0] flash_set;
  assign flash_set = {pat.double_flash, pat.single_flash, pat.blink, pat.flicker};

  // Link and activity come from the port pins; bit order {act_out, link_out, act_in, link_in}.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_s1 <= 4'h0;
      pin_s2 <= 4'h0;
    end else begin
      pin_s1 <= {act_out_i, link_out_i, act_in_i, link_in_i};
      pin_s2 <= pin_s1;
    end
  end

  // Temperature supervision.
  assign temp_hot = $signed(temp_i) > $signed(temp_max_i);
  assign temp_warn = $signed(temp_i) >= $signed(temp_warn_limit_i);

  // Counts whole ticks spent hot; any cool sample restarts the window.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      over_cnt <= 7'h00;
    end else if (!temp_hot) begin
      over_cnt <= 7'h00;
    end else if (pat.tick && over_cnt != DDM_OVER_LIM) begin
      over_cnt <= over_cnt + 7'h01; // R1
    end
  end

  // The class 3 error latches until a fault reset; a new detection wins.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      err_class3_o <= 1'b0;
    end else if (temp_hot && over_cnt == DDM_OVER_LIM) begin
      err_class3_o <= 1'b1; // R1
    end else if (fault_reset_i) begin
      err_class3_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      err_class0_o <= 1'b0;
    end else begin
      err_class0_o <= temp_warn; // R2
    end
  end

  // Load supervision; equality keeps the present decision.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      current_limit_o <= 1'b0;
    end else if (load_integral_i > load_integral_limit_i) begin
      current_limit_o <= 1'b1; // R4
    end else if (load_integral_i < load_integral_limit_i) begin
      current_limit_o <= 1'b0; // R5
    end
  end

  // Read-only parameter port.
  always_comb begin
    addr_hit = 1'b1;
    next_rdata = DDM_RDATA_RESET;
    case (par_addr_i)
      DDM_ADDR_TEMP_WARN: next_rdata = temp_warn_limit_i;
      DDM_ADDR_TEMP_MAX: next_rdata = temp_max_i;
      DDM_ADDR_TEMP_ACT: next_rdata = temp_i; // R3
      DDM_ADDR_OVERLOAD: next_rdata = overload_pct_i; // R6
      DDM_ADDR_MEAN_LOAD: next_rdata = mean_load_pct_i; // R6
      default: addr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      par_ack_o <= 1'b0;
      par_err_o <= 1'b0;
      par_rdata_o <= DDM_RDATA_RESET;
    end else begin
      par_ack_o <= par_rd_i || par_wr_i;
      par_err_o <= par_wr_i || (par_rd_i && !addr_hit); // R3 R6
      if (par_rd_i && !par_wr_i && addr_hit) begin
        par_rdata_o <= next_rdata;
      end
    end
  end

  // Operating-state indicator choice; firmware and internal faults override.
  always_comb begin
    g_pat = DDM_PAT_OFF;
    r_pat = DDM_PAT_OFF;
    if (internal_err_i) begin
      r_pat = DDM_PAT_ON; // R8
    end else if (fw_missing_i) begin
      g_pat = DDM_PAT_FLICKER; // R8
      r_pat = DDM_PAT_FLICKER;
    end else begin
      case (op_state_i)
        DDM_OPS_START, DDM_OPS_NOT_READY: g_pat = DDM_PAT_SINGLE; // R8
        DDM_OPS_SW_ON_DIS: g_pat = DDM_PAT_BLINK; // R8
        DDM_OPS_READY, DDM_OPS_SWITCHED_ON: g_pat = DDM_PAT_DOUBLE; // R8
        DDM_OPS_OP_ENABLED: g_pat = DDM_PAT_ON; // R8
        DDM_OPS_QUICK_STOP, DDM_OPS_FAULT_REACT: begin
          g_pat = DDM_PAT_ON; // R8
          r_pat = DDM_PAT_BLINK;
        end
        DDM_OPS_FAULT: r_pat = DDM_PAT_BLINK; // R8
        default: r_pat = DDM_PAT_ON;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_led_green_o <= 1'b0;
      state_led_red_o <= 1'b0;
    end else begin
      state_led_green_o <= pat_level(g_pat, flash_set); // R7
      state_led_red_o <= pat_level(r_pat, flash_set); // R7
    end
  end

  // Activity is held until the next tick so short bursts stay visible.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      act_recent <= 2'b00;
    end else begin
      act_recent[0] <= pin_s2[1] || (act_recent[0] && !pat.tick);
      act_recent[1] <= pin_s2[3] || (act_recent[1] && !pat.tick);
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bus_led_green_o <= 1'b0;
      bus_led_red_o <= 1'b0;
    end else begin
      bus_led_green_o <= pin_s2[0] && (!act_recent[0] || pat.flicker); // R9
      bus_led_red_o <= pin_s2[2] && (!act_recent[1] || pat.flicker); // R9
    end
  end

  // Run and error indicators of the fieldbus.
  always_comb begin
    case (bus_state_i)
      DDM_BUS_INIT: run_pat = DDM_PAT_OFF; // R10
      DDM_BUS_PREOP: run_pat = DDM_PAT_BLINK; // R10
      DDM_BUS_SAFEOP: run_pat = DDM_PAT_SINGLE; // R10
      DDM_BUS_OP: run_pat = DDM_PAT_ON; // R10
      default: run_pat = DDM_PAT_OFF;
    endcase
    if (wdog_timeout_i) begin
      err_pat = DDM_PAT_DOUBLE; // R11
    end else if (local_err_i) begin
      err_pat = DDM_PAT_SINGLE; // R11
    end else if (invalid_cfg_i) begin
      err_pat = DDM_PAT_BLINK; // R11
    end else begin
      err_pat = DDM_PAT_OFF; // R11
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      run_led_o <= 1'b0;
      err_led_o <= 1'b0;
    end else begin
      run_led_o <= pat_level(run_pat, flash_set);
      err_led_o <= pat_level(err_pat, flash_set);
    end
  end

  over_temp_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R1
    $rose(err_class3_o) |-> $past(temp_hot) && $past(over_cnt) == DDM_OVER_LIM)
    else $error("class 3 raised before persistence expired");

  warn_level_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R2
    ##1 (err_class0_o == ($signed($past(temp_i)) >= $signed($past(temp_warn_limit_i)))))
    else $error("class 0 does not follow warning threshold");

  temp_read_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R3
    (par_rd_i && !par_wr_i && par_addr_i == DDM_ADDR_TEMP_ACT)
    |=> par_ack_o && !par_err_o && par_rdata_o == $past(temp_i))
    else $error("temperature read returned wrong data");

  write_refused_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R3
    par_wr_i |=> par_ack_o && par_err_o && $stable(par_rdata_o))
    else $error("write to read-only parameter accepted");

  limit_set_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R4
    (load_integral_i > load_integral_limit_i) |=> current_limit_o)
    else $error("current not limited above load limit");

  limit_clear_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R5
    (load_integral_i < load_integral_limit_i) |=> !current_limit_o)
    else $error("current limit held below load limit");

  load_read_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R6
    (par_rd_i && !par_wr_i && par_addr_i == DDM_ADDR_MEAN_LOAD)
    |=> par_rdata_o == $past(mean_load_pct_i))
    else $error("mean load read returned wrong data");

  op_enabled_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R8
    (op_state_i == DDM_OPS_OP_ENABLED && !fw_missing_i && !internal_err_i)
    |=> state_led_green_o && !state_led_red_o)
    else $error("operation enabled pattern wrong");

  link_off_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R9
    !pin_s2[0] |=> !bus_led_green_o)
    else $error("link LED lit without link");

  run_led_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R10
    (bus_state_i == DDM_BUS_OP) |=> run_led_o)
    else $error("run LED not steady in operational");

  err_led_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R11
    (!wdog_timeout_i && !local_err_i && !invalid_cfg_i) |=> !err_led_o)
    else $error("error LED lit with no error");

  over_temp_c: cover property (@(posedge clk_i) disable iff (!rst_b_i) $rose(err_class3_o));
  limit_c: cover property (@(posedge clk_i) disable iff (!rst_b_i) $fell(current_limit_o));
  wdog_c: cover property (@(posedge clk_i) disable iff (!rst_b_i)
    wdog_timeout_i && $rose(err_led_o));

endmodule // ddm_diag_monitor

/* verif/ddm_link_partner.sv */
// Link partner model for both fieldbus ports: link level and activity pins.
// Assumes the testbench sets link_up_i and traffic_i, bit 0 incoming, bit 1 outgoing.
`timescale 1ns/1ps
module ddm_link_partner (
  input wire logic clk_i,
  input wire logic [1:0] link_up_i,
  input wire logic [1:0] traffic_i,
  output logic link_in_o,
  output logic act_in_o,
  output logic link_out_o,
  output logic act_out_o
);
  logic frame_bit;

  initial frame_bit = 1'b0;
  always @(posedge clk_i) begin
    frame_bit <= ~frame_bit;
  end

  // Activity toggles every cycle while traffic runs; with no link the pin is pulled low.
  assign link_in_o = link_up_i[0];
  assign link_out_o = link_up_i[1];
  assign act_in_o = link_up_i[0] & traffic_i[0] & frame_bit;
  assign act_out_o = link_up_i[1] & traffic_i[1] & frame_bit;
endmodule // ddm_link_partner

/* verif/ddm_diag_monitor_tb_top.sv */
// Self-checking testbench of the drive diagnostic monitor.
// Assumes TICK_CYCLES is cut to 4, so one tick is 4 cycles of the 8 ns clock.
`timescale 1ns/1ps
module ddm_diag_monitor_tb_top import ddm_pkg::*;;
  localparam int TC = 4;
  localparam int RUN_N [4] = '{32, 32, 96, 32};
  localparam int RUN_E [4] = '{0, 16, 16, 32};
  localparam logic [2:0] ERR_M [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h7};
  localparam int ERR_N [5] = '{32, 32, 96, 128, 128};
  localparam int ERR_E [5] = '{0, 16, 16, 32, 32};
  localparam logic [5:0] ST_M [12] = '{6'h01, 6'h03, 6'h04, 6'h06, 6'h07, 6'h09,
    6'h16, 6'h36, 6'h00, 6'h02, 6'h05, 6'h08};
  localparam int ST_N [12] = '{96, 32, 128, 32, 32, 32, 32, 32, 32, 96, 128, 32};
  localparam int ST_G [12] = '{16, 16, 32, 32, 32, 0, 16, 0, 0, 16, 32, 32};
  localparam int ST_R [12] = '{0, 0, 0, 0, 16, 16, 16, 32, 32, 0, 0, 16};
  localparam logic [3:0] BUS_M [4] = '{4'h0, 4'hC, 4'hD, 4'hB};
  localparam int BUS_G [4] = '{0, 32, 16, 0};
  localparam int BUS_R [4] = '{0, 32, 32, 16};
  logic clk_i, rst_b_i, fault_reset, rd, wr, fw_missing, int_err, wdog, local_err, bad_cfg;
  logic [15:0] temp, warn, tmax, li, lim, ovl, mean, addr, rdata;
  logic [3:0] op_state;
  logic [1:0] bus_state, link_up, traffic;
  logic link_in, act_in, link_out, act_out;
  logic ack, err, c0, c3, climit, sg, sr, bg, br, run, eled;
  logic [5:0] leds;
  int failures, n_checks;

  assign leds = {eled, run, br, bg, sr, sg};

  ddm_diag_monitor #(.TICK_CYCLES(TC)) dut_u (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .temp_i(temp), .temp_warn_limit_i(warn),
    .temp_max_i(tmax), .fault_reset_i(fault_reset), .load_integral_i(li),
    .load_integral_limit_i(lim), .overload_pct_i(ovl), .mean_load_pct_i(mean),
    .par_rd_i(rd), .par_wr_i(wr), .par_addr_i(addr), .par_ack_o(ack), .par_err_o(err),
    .par_rdata_o(rdata), .err_class0_o(c0), .err_class3_o(c3), .current_limit_o(climit),
    .op_state_i(op_state), .fw_missing_i(fw_missing), .internal_err_i(int_err),
    .state_led_green_o(sg), .state_led_red_o(sr), .link_in_i(link_in), .act_in_i(act_in),
    .link_out_i(link_out), .act_out_i(act_out), .bus_led_green_o(bg), .bus_led_red_o(br),
    .bus_state_i(bus_state), .run_led_o(run), .wdog_timeout_i(wdog),
    .local_err_i(local_err), .invalid_cfg_i(bad_cfg), .err_led_o(eled));

  ddm_link_partner partner_u (
    .clk_i(clk_i), .link_up_i(link_up), .traffic_i(traffic), .link_in_o(link_in),
    .act_in_o(act_in), .link_out_o(link_out), .act_out_o(act_out));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  task automatic end_sim();
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // One request; the answer is looked at in the single cycle that it stands.
  task automatic par(input logic w, input logic [15:0] a, input logic e, input logic [15:0] d);
    @(posedge clk_i);
    rd <= ~w;
    wr <= w;
    addr <= a;
    @(posedge clk_i);
    rd <= 1'b0;
    wr <= 1'b0;
    #1;
    chk({14'h0000, ack, err}, {14'h0000, 1'b1, e});
    chk(rdata, d);
  endtask

  // Counts lit cycles of one indicator over a whole pattern period.
  task automatic meas(input int s, input int n, input int exp);
    logic [15:0] ones;
    ones = 16'h0000;
    repeat (n) begin
      @(posedge clk_i);
      #1;
      ones = ones + 16'(leds[s]);
    end
    chk(ones, 16'(exp));
  endtask

  initial begin
    #200000;
    failures++;
    end_sim();
  end

  initial begin
    rst_b_i = 1'b0;
    {fault_reset, rd, wr, fw_missing, int_err, wdog, local_err, bad_cfg} = 8'h00;
    temp = 16'hFFF6;
    warn = 16'h0050;
    tmax = 16'h005A;
    li = 16'h0000;
    lim = 16'h0100;
    ovl = 16'h0096;
    mean = 16'h0041;
    addr = 16'h0000;
    op_state = 4'h1;
    bus_state = 2'h0;
    link_up = 2'h0;
    traffic = 2'h0;
    repeat (3) @(posedge clk_i);
    rst_b_i <= 1'b1;
    cyc(2);
    par(1'b0, DDM_ADDR_TEMP_WARN, 1'b0, 16'h0050);
    par(1'b0, DDM_ADDR_TEMP_MAX, 1'b0, 16'h005A);
    par(1'b0, DDM_ADDR_OVERLOAD, 1'b0, 16'h0096);
    par(1'b0, DDM_ADDR_MEAN_LOAD, 1'b0, 16'h0041);
    par(1'b0, DDM_ADDR_TEMP_ACT, 1'b0, 16'hFFF6);
    par(1'b1, DDM_ADDR_TEMP_ACT, 1'b1, 16'hFFF6);
    par(1'b1, DDM_ADDR_OVERLOAD, 1'b1, 16'hFFF6);
    par(1'b0, 16'h1C22, 1'b1, 16'hFFF6);
    chk({15'h0000, c0}, 16'h0000);
    temp <= 16'h0050;
    cyc(2);
    chk({15'h0000, c0}, 16'h0001);
    temp <= 16'h004F;
    cyc(2);
    chk({15'h0000, c0}, 16'h0000);
    temp <= 16'hFFF6;
    warn <= 16'hFFF0;
    cyc(2);
    chk({15'h0000, c0}, 16'h0001);
    warn <= 16'h0050;
    li <= 16'h0101;
    cyc(2);
    chk({15'h0000, climit}, 16'h0001);
    li <= 16'h0100;
    cyc(2);
    chk({15'h0000, climit}, 16'h0001);
    li <= 16'h00FF;
    cyc(2);
    chk({15'h0000, climit}, 16'h0000);
    li <= 16'h0100;
    cyc(2);
    chk({15'h0000, climit}, 16'h0000);
    temp <= 16'h005A;
    cyc(420);
    chk({15'h0000, c3}, 16'h0000);
    temp <= 16'h005B;
    cyc(300);
    temp <= 16'h0000;
    cyc(2);
    temp <= 16'h005B;
    cyc(400);
    chk({15'h0000, c3}, 16'h0000);
    cyc(20);
    chk({15'h0000, c3}, 16'h0001);
    temp <= 16'h0000;
    cyc(4);
    chk({15'h0000, c3}, 16'h0001);
    fault_reset <= 1'b1;
    cyc(1);
    fault_reset <= 1'b0;
    cyc(3);
    chk({15'h0000, c3}, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      bus_state <= 2'(i);
      cyc(8);
      meas(4, RUN_N[i], RUN_E[i]);
    end
    for (int i = 0; i < 5; i++) begin
      {wdog, local_err, bad_cfg} <= ERR_M[i];
      cyc(8);
      meas(5, ERR_N[i], ERR_E[i]);
    end
    for (int i = 0; i < 12; i++) begin
      {int_err, fw_missing, op_state} <= ST_M[i];
      cyc(8);
      meas(0, ST_N[i], ST_G[i]);
      meas(1, ST_N[i], ST_R[i]);
    end
    for (int i = 0; i < 4; i++) begin
      {link_up, traffic} <= BUS_M[i];
      cyc(8);
      meas(2, 32, BUS_G[i]);
      meas(3, 32, BUS_R[i]);
    end
    end_sim();
  end
endmodule // ddm_diag_monitor_tb_top
